// [rtl/module_mgmt_status_map.sv]
// Management status map behind the two-wire serial management pins
`timescale 1ns/100ps
`include "mgmt_map_params.svh"

// Behaviour
// (R1) Byte 0 returns module type code
// (R2) Byte 1 returns revision, major high nibble
// (R3) Byte 2 bit 7 flags flat memory
// (R4) Byte 2 bit 6 flags stepwise reconfiguration
// (R5) Stepwise: init apply accepted, datapath unchanged
// (R6) Stepwise: immediate apply writes ignored
// (R7) Byte 2 bits 3-2 give link speed
// (R8) Byte 3 bits 3-1 give module state
// (R9) Output verification reports code 110b
// (R10) Flat memory always reports ready state
// (R11) Byte 3 bit 0 high when irq idle
// (R12) Lower page addressable regardless of page
// (R13) Host selects page shown in upper memory
// (R14) Pages 01h/02h byte 255 hold checksums
// (R15) Page 03h exposes non-volatile user data
// (R16) Host checks type code against its list
// (R17) Host reads fields after recognising module
// (R18) Bytes 126-127 hold bank and page select
// (R19) Reserved bits zero, read-only writes ignored
module module_mgmt_status_map #(
   parameter logic [7:0] TYPE_CODE = 8'hA5,  // Arbitrary value
   parameter logic [3:0] REV_MAJOR = 4'h1,
   parameter logic [3:0] REV_MINOR = 4'h0,
   parameter bit         FLAT_MEM  = 1'b0,
   parameter bit         STEPWISE  = 1'b0,
   parameter logic [1:0] MAX_SPEED = 2'b00
) (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // Serial management pins
   input  wire logic                  scl_in,
   input  wire logic                  sda_in,
   output logic                       sda_out,
   output logic                       sda_oe_n,
   // Module controller status
   input  wire logic [2:0]            module_state_code,
   input  wire logic                  output_verify,
   input  wire logic                  irq_active,
   input  wire mgmt_map_pkg::nv_load_t nv_load,
   // Control outputs
   output logic [7:0]                 page_sel,
   output logic [7:0]                 bank_sel,
   output logic                       datapath_init_apply,
   output logic                       immediate_apply,
   output logic                       dp_state_hold
);

   mgmt_map_pkg::link_state_t state_reg;
   logic [2:0]  scl_sync_reg;
   logic [2:0]  sda_sync_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  tx_reg;
   logic [7:0]  ptr_reg;
   logic        rw_reg;
   logic        first_reg;
   logic        ack_ok_reg;
   logic [7:0]  chk1_reg;
   logic [7:0]  chk2_reg;
   logic [7:0]  adv_mem [0:383];

   // Pin synchronisers: stage 0 only feeds stage 1
   always_ff @(posedge core_clk) begin
      if (rst) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      end
   end

   // Bus events from the settled samples
   wire scl_now    = scl_sync_reg[1];
   wire scl_old    = scl_sync_reg[2];
   wire sda_now    = sda_sync_reg[1];
   wire sda_old    = sda_sync_reg[2];
   wire scl_rise   = scl_now & ~scl_old;
   wire scl_fall   = ~scl_now & scl_old;
   wire start_cond = scl_now & scl_old & ~sda_now & sda_old;
   wire stop_cond  = scl_now & scl_old & sda_now & ~sda_old;

   // Fixed characteristic bytes and live status byte
   wire [7:0] rev_byte  = {REV_MAJOR, REV_MINOR};                           // [R2]
   wire [7:0] char_byte = {FLAT_MEM, STEPWISE, 2'b00, MAX_SPEED, 2'b00};    // [R3] [R4] [R7] [R19]
   wire [2:0] state_field = FLAT_MEM      ? `MM_STATE_READY :               // [R10]
                            output_verify ? `MM_STATE_VERIFY :              // [R9]
                            module_state_code;                              // [R8]
   wire [7:0] status_byte = {4'h0, state_field, ~irq_active};               // [R11] [R19]

   // Lower page decode never looks at the page select
   wire [7:0] lower_rd =                                                    // [R12]
      (ptr_reg == `MM_OFS_TYPE)     ? TYPE_CODE :                           // [R1]
      (ptr_reg == `MM_OFS_REV)      ? rev_byte :
      (ptr_reg == `MM_OFS_CHAR)     ? char_byte :
      (ptr_reg == `MM_OFS_STATUS)   ? status_byte :
      (ptr_reg == `MM_OFS_BANK_SEL) ? bank_sel :                            // [R18]
      (ptr_reg == `MM_OFS_PAGE_SEL) ? page_sel : 8'h00;

   // Upper page decode; flat memory only ever shows page 00h
   // Page 0 would index past the store, but its lookup is never selected
   wire [7:0] eff_page = FLAT_MEM ? `MM_PAGE_ID : page_sel;                 // [R3] [R13]
   wire [1:0] rd_pg_m1 = 2'(eff_page[1:0] - 2'd1);
   wire [7:0] adv_rd   = adv_mem[{rd_pg_m1, ptr_reg[6:0]}];
   wire       at_sum   = (ptr_reg == `MM_OFS_CHECKSUM);
   wire [7:0] upper_rd =
      (eff_page == `MM_PAGE_ID)   ? ((ptr_reg == `MM_OFS_TYPE_COPY) ? TYPE_CODE : 8'h00) :
      (eff_page == `MM_PAGE_ADV)  ? (at_sum ? chk1_reg : adv_rd) :          // [R14]
      (eff_page == `MM_PAGE_THR)  ? (at_sum ? chk2_reg : adv_rd) :          // [R14]
      (eff_page == `MM_PAGE_USER) ? adv_rd : 8'h00;                         // [R15]
   wire [7:0] rd_byte  = ptr_reg[7] ? upper_rd : lower_rd;

   // Byte completion strobes
   wire byte_done = scl_fall && (state_reg == mgmt_map_pkg::ST_WRITE)
                    && (bit_cnt_reg == `MM_BITS_PER_BYTE);
   wire wr_stb    = byte_done && !first_reg;
   wire ld_tx     = scl_fall && ((state_reg == mgmt_map_pkg::ST_ACK && rw_reg)
                    || (state_reg == mgmt_map_pkg::ST_RACK && ack_ok_reg));
   wire wr_dpctl  = wr_stb && !FLAT_MEM && (page_sel == `MM_PAGE_DPCTL);

   // Serial slave sequencer: address, pointer, data bytes and acks
   // Sda only moves once scl is seen low, so the device's own edges
   // can never look like a start or stop to the other party
   // Pointer wraps from 255 to 0 on reads and writes alike
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg   <= mgmt_map_pkg::ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         tx_reg      <= 8'h00;
         ptr_reg     <= 8'h00;
         rw_reg      <= 1'b0;
         first_reg   <= 1'b0;
         ack_ok_reg  <= 1'b0;
         sda_oe_n    <= 1'b1;
      end else if (stop_cond) begin
         state_reg <= mgmt_map_pkg::ST_IDLE;
         sda_oe_n  <= 1'b1;
      end else if (start_cond) begin
         state_reg   <= mgmt_map_pkg::ST_DEVADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe_n    <= 1'b1;
      end else begin
         case (state_reg)
            mgmt_map_pkg::ST_DEVADDR, mgmt_map_pkg::ST_WRITE: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_now};
                  bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
               end else if (scl_fall && bit_cnt_reg == `MM_BITS_PER_BYTE) begin
                  bit_cnt_reg <= 4'h0;
                  if (state_reg == mgmt_map_pkg::ST_WRITE) begin
                     sda_oe_n  <= 1'b0;
                     state_reg <= mgmt_map_pkg::ST_ACK;
                     first_reg <= 1'b0;
                     ptr_reg   <= first_reg ? shift_reg : 8'(ptr_reg + 8'h01);
                  end else if (shift_reg[7:1] == `MM_DEV_ADDR) begin
                     sda_oe_n  <= 1'b0;
                     rw_reg    <= shift_reg[0];
                     first_reg <= ~shift_reg[0];
                     state_reg <= mgmt_map_pkg::ST_ACK;
                  end else begin
                     state_reg <= mgmt_map_pkg::ST_IDLE;
                  end
               end
            end
            mgmt_map_pkg::ST_ACK, mgmt_map_pkg::ST_RACK: begin
               if (scl_rise) begin
                  ack_ok_reg <= ~sda_now;
               end
               if (ld_tx) begin
                  // Reads advance the pointer as each byte is loaded
                  tx_reg      <= rd_byte;
                  sda_oe_n    <= rd_byte[7];
                  ptr_reg     <= 8'(ptr_reg + 8'h01);
                  bit_cnt_reg <= 4'h1;
                  state_reg   <= mgmt_map_pkg::ST_READ;
               end else if (scl_fall) begin
                  sda_oe_n  <= 1'b1;
                  state_reg <= rw_reg ? mgmt_map_pkg::ST_IDLE : mgmt_map_pkg::ST_WRITE;
               end
            end
            mgmt_map_pkg::ST_READ: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == `MM_BITS_PER_BYTE) begin
                     sda_oe_n    <= 1'b1;
                     bit_cnt_reg <= 4'h0;
                     state_reg   <= mgmt_map_pkg::ST_RACK;
                  end else begin
                     tx_reg      <= {tx_reg[6:0], 1'b0};
                     sda_oe_n    <= tx_reg[6];
                     bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                  end
               end
            end
            default: begin
               sda_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // Only the page mapping and page 10h apply bytes take host writes
   // Apply pulses last one cycle; the hold level reports stepwise mode
   // Open drain: the driven value stays low and only oe_n moves
   always_ff @(posedge core_clk) begin
      if (rst) begin
         page_sel            <= `MM_RST_PAGE;
         bank_sel            <= `MM_RST_BANK;
         datapath_init_apply <= 1'b0;
         immediate_apply     <= 1'b0;
         dp_state_hold       <= 1'b0;
         sda_out             <= 1'b0;
      end else begin
         if (wr_stb && ptr_reg == `MM_OFS_PAGE_SEL) begin
            page_sel <= shift_reg;                                          // [R13] [R18]
         end
         if (wr_stb && ptr_reg == `MM_OFS_BANK_SEL) begin
            bank_sel <= shift_reg;                                          // [R18] [R19]
         end
         datapath_init_apply <= wr_dpctl && (ptr_reg == `MM_OFS_DP_INIT);   // [R5]
         immediate_apply     <= wr_dpctl && (ptr_reg == `MM_OFS_IMM_APPLY)
                                && !STEPWISE;                               // [R6]
         dp_state_hold       <= STEPWISE;                                   // [R5]
         sda_out             <= 1'b0;
      end
   end

   // Advertising, threshold and user pages; checksums track each load inside their ranges
   wire [1:0] ld_pg_m1 = 2'(nv_load.page - 2'd1);
   wire [8:0] ld_idx   = {ld_pg_m1, nv_load.offset};
   wire [7:0] ld_old   = adv_mem[ld_idx];
   wire       ld_ok    = nv_load.valid && (nv_load.page != 2'd0);
   wire       ld_in_p1 = ld_ok && (nv_load.page == 2'd1)
                         && (nv_load.offset >= `MM_P1_SUM_FIRST)
                         && (nv_load.offset <= `MM_SUM_LAST);
   wire       ld_in_p2 = ld_ok && (nv_load.page == 2'd2)
                         && (nv_load.offset >= `MM_P2_SUM_FIRST)
                         && (nv_load.offset <= `MM_SUM_LAST);
   wire [7:0] ld_delta = 8'(nv_load.data - ld_old);

   // Reset clears the store so the running sums start from a known zero
   // Running sums trade an adder per page for a walk over 125 bytes (page 1) or 127 bytes (page 2)
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < 384; i++) begin
            adv_mem[i] <= 8'h00;
         end
         chk1_reg <= 8'h00;
         chk2_reg <= 8'h00;
      end else begin
         if (ld_ok) begin
            adv_mem[ld_idx] <= nv_load.data;                                // [R15]
         end
         if (ld_in_p1) begin
            chk1_reg <= 8'(chk1_reg + ld_delta);                            // [R14]
         end
         if (ld_in_p2) begin
            chk2_reg <= 8'(chk2_reg + ld_delta);                            // [R14]
         end
      end
   end

   // Checks on what the host sees
   a_type_read: assert property (@(posedge core_clk) disable iff (rst)  // [R1]
      ld_tx && ptr_reg == `MM_OFS_TYPE |=> tx_reg == TYPE_CODE)
      else $error("type code byte wrong");
   a_rev_nibbles: assert property (@(posedge core_clk) disable iff (rst)  // [R2]
      ld_tx && ptr_reg == `MM_OFS_REV |=> tx_reg[7:4] == REV_MAJOR && tx_reg[3:0] == REV_MINOR)
      else $error("revision nibbles wrong");
   a_char_read: assert property (@(posedge core_clk) disable iff (rst)  // [R3] [R4] [R7]
      ld_tx && ptr_reg == `MM_OFS_CHAR
      |=> tx_reg[7] == FLAT_MEM && tx_reg[6] == STEPWISE && tx_reg[3:2] == MAX_SPEED
          && tx_reg[5:4] == 2'b00 && tx_reg[1:0] == 2'b00)
      else $error("characteristics byte wrong");
   a_status_read: assert property (@(posedge core_clk) disable iff (rst)  // [R11]
      ld_tx && ptr_reg == `MM_OFS_STATUS
      |=> tx_reg[0] == !$past(irq_active) && tx_reg[7:4] == 4'h0)
      else $error("status byte wrong");

   // Status codes, apply handling, page writes and checksums
   a_flat_ready: assert property (@(posedge core_clk) disable iff (rst)  // [R10]
      ld_tx && ptr_reg == `MM_OFS_STATUS && FLAT_MEM
      |=> tx_reg[3:1] == `MM_STATE_READY)
      else $error("flat memory not ready");
   a_verify_code: assert property (@(posedge core_clk) disable iff (rst)  // [R9]
      ld_tx && ptr_reg == `MM_OFS_STATUS && !FLAT_MEM && output_verify
      |=> tx_reg[3:1] == `MM_STATE_VERIFY)
      else $error("verify state code wrong");
   a_imm_ignored: assert property (@(posedge core_clk) disable iff (rst)  // [R6]
      wr_dpctl && ptr_reg == `MM_OFS_IMM_APPLY |=> immediate_apply == !STEPWISE)
      else $error("immediate apply handling wrong");
   a_dp_init: assert property (@(posedge core_clk) disable iff (rst)  // [R5]
      wr_dpctl && ptr_reg == `MM_OFS_DP_INIT |=> datapath_init_apply && dp_state_hold == STEPWISE)
      else $error("init apply not accepted");
   a_page_write: assert property (@(posedge core_clk) disable iff (rst)  // [R13]
      wr_stb && ptr_reg == `MM_OFS_PAGE_SEL |=> page_sel == $past(shift_reg))
      else $error("page select not stored");
   a_ro_ignored: assert property (@(posedge core_clk) disable iff (rst)  // [R19]
      wr_stb && ptr_reg < `MM_OFS_BANK_SEL |=> $stable(page_sel) && $stable(bank_sel))
      else $error("read-only write had effect");
   a_sum_read: assert property (@(posedge core_clk) disable iff (rst)  // [R14]
      ld_tx && ptr_reg == `MM_OFS_CHECKSUM && eff_page == `MM_PAGE_ADV
      |=> tx_reg == $past(chk1_reg))
      else $error("checksum byte wrong");
   a_thr_sum: assert property (@(posedge core_clk) disable iff (rst)  // [R14]
      ld_tx && ptr_reg == `MM_OFS_CHECKSUM && eff_page == `MM_PAGE_THR
      |=> tx_reg == $past(chk2_reg))
      else $error("threshold checksum byte wrong");

   // Lower page and page mapping bytes
   a_state_code: assert property (@(posedge core_clk) disable iff (rst)  // [R8]
      ld_tx && ptr_reg == `MM_OFS_STATUS && !FLAT_MEM && !output_verify
      |=> tx_reg[3:1] == $past(module_state_code))
      else $error("module state code wrong");
   a_speed_legal: assert property (@(posedge core_clk) disable iff (rst)  // [R7]
      ld_tx && ptr_reg == `MM_OFS_CHAR |=> !tx_reg[3])
      else $error("reserved link speed code");
   a_lower_unpaged: assert property (@(posedge core_clk) disable iff (rst)  // [R12]
      ld_tx && ptr_reg == `MM_OFS_TYPE && page_sel != `MM_PAGE_ID
      |=> tx_reg == TYPE_CODE)
      else $error("lower page followed page select");
   a_bank_read: assert property (@(posedge core_clk) disable iff (rst)  // [R18]
      ld_tx && ptr_reg == `MM_OFS_BANK_SEL |=> tx_reg == $past(bank_sel))
      else $error("bank select readback wrong");
   a_bank_write: assert property (@(posedge core_clk) disable iff (rst)  // [R18]
      wr_stb && ptr_reg == `MM_OFS_BANK_SEL |=> bank_sel == $past(shift_reg))
      else $error("bank select not stored");

   // Apply controls move only after a page 10h write
   a_hold_level: assert property (@(posedge core_clk) disable iff (rst)  // [R5]
      !$past(rst) |-> dp_state_hold == STEPWISE)
      else $error("datapath hold level wrong");
   a_pulse_cause: assert property (@(posedge core_clk) disable iff (rst)  // [R5] [R6]
      !wr_dpctl |=> !datapath_init_apply && !immediate_apply)
      else $error("apply pulse without a write");
   a_flat_quiet: assert property (@(posedge core_clk) disable iff (rst)  // [R3]
      FLAT_MEM |-> !datapath_init_apply && !immediate_apply)
      else $error("flat memory pulsed an apply");

endmodule

// [rtl/mgmt_map_params.svh]
// Offsets, field codes and reset values of the management status map
`ifndef MGMT_MAP_PARAMS_SVH
`define MGMT_MAP_PARAMS_SVH
`define MM_DEV_ADDR        7'h50
`define MM_OFS_TYPE        8'h00
`define MM_OFS_REV         8'h01
`define MM_OFS_CHAR        8'h02
`define MM_OFS_STATUS      8'h03
`define MM_OFS_BANK_SEL    8'h7E
`define MM_OFS_PAGE_SEL    8'h7F
`define MM_OFS_TYPE_COPY   8'h80
`define MM_OFS_CHECKSUM    8'hFF
`define MM_OFS_DP_INIT     8'h8F
`define MM_OFS_IMM_APPLY   8'h90
`define MM_P1_SUM_FIRST    7'h02
`define MM_P2_SUM_FIRST    7'h00
`define MM_SUM_LAST        7'h7E
`define MM_PAGE_ID         8'h00
`define MM_PAGE_ADV        8'h01
`define MM_PAGE_THR        8'h02
`define MM_PAGE_USER       8'h03
`define MM_PAGE_DPCTL      8'h10
`define MM_STATE_READY     3'h3
`define MM_STATE_VERIFY    3'h6
`define MM_RST_PAGE        8'h00
`define MM_RST_BANK        8'h00
`define MM_BITS_PER_BYTE   4'h8
`endif

// [rtl/mgmt_map_pkg.sv]
// Types shared by the management status map
package mgmt_map_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEVADDR, ST_WRITE, ST_ACK, ST_READ, ST_RACK
   } link_state_t;

   // One byte loaded from non-volatile storage or the module controller
   typedef struct packed {
      logic       valid;
      logic [1:0] page;
      logic [6:0] offset;
      logic [7:0] data;
   } nv_load_t;
endpackage

// [sim/mgmt_host_model.sv]
// Host controller model that bit-bangs the two-wire management link
`timescale 1ns/100ps
module mgmt_host_model (
   // Clock for pacing the link
   input  wire logic core_clk,
   // Resolved data wire
   input  wire logic sda_pin,
   // Open-drain drives, 1 releases the wire
   output logic      scl_out,
   output logic      sda_drv
);
   // Both lines released until the first frame
   initial begin
      scl_out = 1'b1;
      sda_drv = 1'b1;
   end

   // Quarters of 8,8,8,7 cycles give a 124 ns bit
   task automatic q(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Data only moves while clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_drv <= b;
      q(8);
      scl_out <= 1'b1;
      q(8);
      r = sda_pin;
      q(8);
      scl_out <= 1'b0;
      q(7);
   endtask

   // Also serves as repeated start
   task automatic start();
      sda_drv <= 1'b1;
      q(4);
      scl_out <= 1'b1;
      q(8);
      sda_drv <= 1'b0;
      q(8);
      scl_out <= 1'b0;
      q(8);
   endtask

   task automatic stop();
      sda_drv <= 1'b0;
      q(8);
      scl_out <= 1'b1;
      q(8);
      sda_drv <= 1'b1;
      q(8);
   endtask

   // Eight bits MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(last, ack);
   endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the management status map
`timescale 1ns/100ps
`include "mgmt_map_params.svh"
module tb_top;
   localparam logic [7:0] TYPE_C = 8'h3C;  // Arbitrary value
   logic                   core_clk;
   logic                   rst;
   logic [2:0]             st_code;
   logic                   ov;
   logic                   irq;
   mgmt_map_pkg::nv_load_t nv;
   logic                   sda_out;
   logic                   sda_oe_n;
   logic                   dp_hold;
   logic                   init_p;
   logic                   imm_p;
   logic                   scl;
   logic                   sda_drv;
   wire logic              sda_pin;
   logic [7:0]             page_sel;
   logic [7:0]             bank_sel;
   logic [7:0]             rb;
   logic [7:0]             sum;
   logic [31:0]            lfsr;
   int                     errors = 0;
   int                     n_tests = 0;
   int                     n_init = 0;
   int                     n_imm = 0;
   logic                   hold_f;
   logic                   init_f;
   logic                   imm_f;
   logic [7:0]             page_f;
   int                     n_flat = 0;

   // Pull-up: wire low whenever either party pulls
   assign sda_pin = (sda_oe_n | sda_out) & sda_drv;

   module_mgmt_status_map #(.TYPE_CODE(TYPE_C), .REV_MAJOR(4'h5), .REV_MINOR(4'h2),
      .FLAT_MEM(1'b0), .STEPWISE(1'b1), .MAX_SPEED(2'b01)) i_dut (
      .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_pin),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .module_state_code(st_code),
      .output_verify(ov), .irq_active(irq), .nv_load(nv), .page_sel(page_sel),
      .bank_sel(bank_sel), .datapath_init_apply(init_p), .immediate_apply(imm_p),
      .dp_state_hold(dp_hold));

   // Flat, non-stepwise twin listens on the same wires but never drives them
   module_mgmt_status_map #(.TYPE_CODE(TYPE_C), .REV_MAJOR(4'h5), .REV_MINOR(4'h2),
      .FLAT_MEM(1'b1), .STEPWISE(1'b0), .MAX_SPEED(2'b00)) i_dut_flat (
      .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_pin),
      .sda_out(), .sda_oe_n(), .module_state_code(st_code),
      .output_verify(ov), .irq_active(irq), .nv_load(nv), .page_sel(page_f),
      .bank_sel(), .datapath_init_apply(init_f), .immediate_apply(imm_f),
      .dp_state_hold(hold_f));

   mgmt_host_model i_host (.core_clk(core_clk), .sda_pin(sda_pin), .scl_out(scl),
      .sda_drv(sda_drv));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Pulses are one cycle wide, so count them as they pass
   always @(posedge core_clk) begin
      if (init_p === 1'b1) n_init++;
      if (imm_p === 1'b1) n_imm++;
      if (init_f === 1'b1 || imm_f === 1'b1) n_flat++;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] nxt(input logic [31:0] l);
      return {l[30:0], 1'b0} ^ (l[31] ? 32'h04C11DB7 : 32'h0);
   endfunction

   function automatic logic [7:0] exp_st(input logic [2:0] s, input logic v, input logic i);
      return {4'h0, v ? 3'h6 : s, ~i};
   endfunction

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] r;
      logic       a;
      i_host.start();
      i_host.xfer({`MM_DEV_ADDR, 1'b0}, 1'b1, r, a);
      i_host.xfer(p, 1'b1, r, a);
      i_host.xfer(d, 1'b1, r, a);
      i_host.stop();
   endtask

   // Single-byte read ended by a host NACK
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic [7:0] r;
      logic       a;
      i_host.start();
      i_host.xfer({`MM_DEV_ADDR, 1'b0}, 1'b1, r, a);
      i_host.xfer(p, 1'b1, r, a);
      i_host.start();
      i_host.xfer({`MM_DEV_ADDR, 1'b1}, 1'b1, r, a);
      i_host.xfer(8'hFF, 1'b1, d, a);
      i_host.stop();
   endtask

   task automatic load(input logic [1:0] pg, input logic [6:0] o, input logic [7:0] d);
      nv <= '{1'b1, pg, o, d};
      @(posedge core_clk);
      nv <= '0;
      @(posedge core_clk);
   endtask

   task automatic conclude();
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      lfsr = 32'hdbb69a37;
      rst = 1'b1;
      st_code = 3'h1;
      ov = 1'b0;
      irq = 1'b0;
      nv = '0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      // Identity is read before any field it qualifies
      rd(8'h00, rb);
      chk(rb, TYPE_C);
      $display("test identity done");
      // Codes 1..5 in turn, then verification over a random code
      for (int k = 0; k < 6; k++) begin
         lfsr = nxt(lfsr);
         st_code <= (k == 5) ? lfsr[2:0] : 3'(k + 1);
         ov <= (k == 5);
         irq <= lfsr[8];
         wr(8'h02, 8'hFF);
         wr(8'h03, 8'hFF);
         rd(8'h01, rb);
         chk(rb, 8'h52);
         rd(8'h02, rb);
         chk(rb, 8'h44);
         rd(8'h03, rb);
         chk(rb, exp_st(st_code, ov, irq));
         $display("test status round %0d done", k);
      end
      // Page and bank select, user data page, lower page still visible
      wr(`MM_OFS_PAGE_SEL, 8'h03);
      chk(page_sel, 8'h03);
      wr(`MM_OFS_BANK_SEL, 8'h5A);
      rd(`MM_OFS_BANK_SEL, rb);
      chk(rb, 8'h5A);
      lfsr = nxt(lfsr);
      load(2'h3, lfsr[6:0], lfsr[15:8]);
      rd({1'b1, lfsr[6:0]}, rb);
      chk(rb, lfsr[15:8]);
      rd(8'h00, rb);
      chk(rb, TYPE_C);
      $display("test paging done");
      // Checksum ranges differ: page 1 skips 128-129
      for (int p = 1; p < 3; p++) begin
         sum = 8'h00;
         for (int o = 0; o < 4; o++) begin
            lfsr = nxt(lfsr);
            load(2'(p), 7'(o), lfsr[7:0]);
            if (o >= 2 || p == 2) sum += lfsr[7:0];
         end
         load(2'(p), 7'h7E, 8'hC3);
         sum += 8'hC3;
         load(2'(p), 7'h7F, 8'h77);
         wr(`MM_OFS_PAGE_SEL, 8'(p));
         rd(`MM_OFS_CHECKSUM, rb);
         chk(rb, sum);
      end
      $display("test checksum done");
      // Stepwise device: init apply pulses, immediate apply dropped
      wr(`MM_OFS_PAGE_SEL, `MM_PAGE_DPCTL);
      wr(`MM_OFS_DP_INIT, 8'h01);
      wr(`MM_OFS_IMM_APPLY, 8'h01);
      chk(8'(n_init), 8'h01);
      chk(8'(n_imm), 8'h00);
      chk({7'h0, dp_hold}, 8'h01);
      chk(8'(n_flat), 8'h00);
      chk({7'h0, hold_f}, 8'h00);
      chk(page_f, `MM_PAGE_DPCTL);
      $display("test apply done");
      // Mid-run reset returns the page mapping to its reset values
      rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(page_sel, `MM_RST_PAGE);
      chk(page_f, `MM_RST_PAGE);
      rd(`MM_OFS_BANK_SEL, rb);
      chk(rb, `MM_RST_BANK);
      $display("test reset done");
      conclude();
   end

   // Watchdog well beyond the expected 47k cycles
   initial begin
      repeat (90000) @(posedge core_clk);
      errors++;
      conclude();
   end
endmodule
